// File: wwdt_map.vh
`ifndef WWDT_MAP_VH
`define WWDT_MAP_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define WWDT_OFS_RESTART    4'h0
`define WWDT_OFS_CONFIG     4'h4
`define WWDT_OFS_FAULT      4'h8
`define WWDT_OFS_IRQ_MASK   4'hc

// ****************************************************************
// restart control fields
// ****************************************************************
`define WWDT_KEY_HI         31
`define WWDT_KEY_LO         24
`define WWDT_KEY_VALUE      8'ha5
`define WWDT_RESTART_BIT    0

// ****************************************************************
// configuration fields
// ****************************************************************
`define WWDT_CFG_RESET      32'h3fff2fff
`define WWDT_COUNT_RESET    12'hfff
`define WWDT_RELOAD_HI      11
`define WWDT_RELOAD_LO      0
`define WWDT_IRQEN_BIT      12
`define WWDT_RSTEN_BIT      13
`define WWDT_PROC_BIT       14
`define WWDT_DIS_BIT        15
`define WWDT_DELTA_HI       27
`define WWDT_DELTA_LO       16
`define WWDT_DBG_BIT        28
`define WWDT_IDLE_BIT       29

// ****************************************************************
// fault flags and timing
// ****************************************************************
`define WWDT_UNF_BIT        0
`define WWDT_ERR_BIT        1
`define WWDT_MASK_RESET     2'h3
`define WWDT_PRESCALE_LAST  7'h7f
`define WWDT_AXI_OKAY       2'h0
`define WWDT_AXI_SLVERR     2'h2

`endif

// File: wwdt_top.v
// Summary of operation
// - control writes take effect only when the top byte carries key 0xa5
// - correct key with restart bit one restarts; restart bit zero does nothing
// - low twelve configuration bits are the value loaded on every reload
// - fault interrupt enable lets underflow or window error raise the interrupt
// - fault reset enable lets underflow or window error request a watchdog reset
// - reset scope bit: zero requests all resets, one only processor reset
// - restart with counter at or below window delta reloads without error
// - restart with counter above window delta raises a window error instead
// - debug halt bit stops counting while the processor is in debug
// - idle halt bit stops counting while the system is idle
// - disable bit one stops counting but leaves the window error check active, zero leaves it running
// - underflow flag reads one if an underflow happened since last read
// - error flag reads one if a window error happened since last read
// - configuration takes only the first write after reset, resets to default
// - counter decrements once per divide-by-128 prescaler tick
// - valid restart reloads counter and restarts the prescaler at once
// - status read or reset clears flags, interrupt and fault line
// - accepted configuration write also reloads and restarts the count
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_map.vh"

module wwdt_top
(
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // slow clock tick and processor state, from other clock domains
  input  wire        slow_clk_tick,
  input  wire        debug_state,
  input  wire        idle_state,
  // axi4-lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // fault outputs
  output reg         irq,
  output reg         fault_all_reset,
  output reg         fault_proc_reset
);

  // ****************************************************************
  // reset release and input synchronisers
  // ****************************************************************
  reg        rst_meta_ff;
  reg        rst_sync_ff;
  wire       rst_n;
  reg  [2:0] in_meta_ff;
  reg  [2:0] in_sync_ff;
  reg        tick_prev_ff;

  // release is synchronous so every flop leaves reset on the same edge
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // two flops per pin; the second stage feeds logic, plus a third flop on the tick for edge detect
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_meta_ff   <= 3'h0;
      in_sync_ff   <= 3'h0;
      tick_prev_ff <= 1'b0;
    end
    else
    begin
      in_meta_ff   <= {idle_state, debug_state, slow_clk_tick};
      in_sync_ff   <= in_meta_ff;
      tick_prev_ff <= in_sync_ff[0];
    end
  end

  // one-cycle enable per slow clock rising edge
  wire slow_en  = in_sync_ff[0] & ~tick_prev_ff;
  wire dbg_sync = in_sync_ff[1];
  wire idle_sync = in_sync_ff[2];

  // ****************************************************************
  // register state
  // ****************************************************************
  reg  [31:0] cfg_ff;
  reg         cfg_locked_ff;
  reg  [11:0] count_ff;
  reg  [6:0]  presc_ff;
  reg         unf_flag_ff;
  reg         err_flag_ff;
  reg  [1:0]  irq_mask_ff;

  wire [11:0] reload_value    = cfg_ff[`WWDT_RELOAD_HI:`WWDT_RELOAD_LO];
  wire [11:0] window_delta    = cfg_ff[`WWDT_DELTA_HI:`WWDT_DELTA_LO];
  wire        fault_irq_enable   = cfg_ff[`WWDT_IRQEN_BIT];
  wire        fault_reset_enable = cfg_ff[`WWDT_RSTEN_BIT];
  wire        processor_only_reset = cfg_ff[`WWDT_PROC_BIT];
  wire        counter_disable = cfg_ff[`WWDT_DIS_BIT];
  wire        debug_halt      = cfg_ff[`WWDT_DBG_BIT];
  wire        idle_halt       = cfg_ff[`WWDT_IDLE_BIT];

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  reg        aw_held_ff;
  reg        w_held_ff;
  reg [3:0]  aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0]  w_strb_ff;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  // write executes once both halves are held and no response is pending
  wire wr_do   = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  wire wr_full = &w_strb_ff;

  // address and data may arrive in either order; each is held once taken
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      aw_addr_ff    <= 4'h0;
      w_data_ff     <= 32'h0;
      w_strb_ff     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WWDT_AXI_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held_ff & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_ff & ~w_take & ~s_axi_bvalid;
      if (aw_take)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_ff)
          `WWDT_OFS_RESTART,
          `WWDT_OFS_CONFIG,
          `WWDT_OFS_FAULT,
          `WWDT_OFS_IRQ_MASK: s_axi_bresp <= `WWDT_AXI_OKAY;
          default:            s_axi_bresp <= `WWDT_AXI_SLVERR;
        endcase
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // partial-strobe writes are ignored: the key and config need whole words
  wire key_ok     = (w_data_ff[`WWDT_KEY_HI:`WWDT_KEY_LO] == `WWDT_KEY_VALUE);
  wire cr_write   = wr_do & wr_full & (aw_addr_ff == `WWDT_OFS_RESTART) & key_ok;
  wire restart_request = cr_write & w_data_ff[`WWDT_RESTART_BIT];
  wire cfg_write  = wr_do & wr_full & (aw_addr_ff == `WWDT_OFS_CONFIG) & ~cfg_locked_ff;
  wire mask_write = wr_do & wr_full & (aw_addr_ff == `WWDT_OFS_IRQ_MASK);

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  wire ar_take = s_axi_arvalid & s_axi_arready;
  // a taken read of the fault flags clears them
  wire sr_read = ar_take & (s_axi_araddr == `WWDT_OFS_FAULT);

  // one read at a time; data answered the cycle after the address is taken
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `WWDT_AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~s_axi_arready;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `WWDT_AXI_OKAY;
        case (s_axi_araddr)
          `WWDT_OFS_RESTART:  s_axi_rdata <= 32'h0;
          `WWDT_OFS_CONFIG:   s_axi_rdata <= cfg_ff;
          `WWDT_OFS_FAULT:    s_axi_rdata <= {30'h0, err_flag_ff, unf_flag_ff};
          `WWDT_OFS_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_ff};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `WWDT_AXI_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // configuration register, written once, and interrupt mask, written any time
  // ****************************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_ff        <= `WWDT_CFG_RESET;
      cfg_locked_ff <= 1'b0;
      irq_mask_ff   <= `WWDT_MASK_RESET;
    end
    else
    begin
      if (cfg_write)
      begin
        cfg_ff        <= w_data_ff;
        cfg_locked_ff <= 1'b1;
      end
      if (mask_write)
        irq_mask_ff <= w_data_ff[1:0];
    end
  end

  // ****************************************************************
  // prescaler and down counter
  // ****************************************************************
  // halts from debug or idle freeze both prescaler and counter
  wire halted   = counter_disable
                | (debug_halt & dbg_sync)
                | (idle_halt & idle_sync);
  wire run_tick = slow_en & ~halted;
  wire presc_wrap = run_tick & (presc_ff == `WWDT_PRESCALE_LAST);
  // error check runs even while disabled
  wire in_window  = (count_ff <= window_delta);
  wire good_restart = restart_request & in_window;
  wire window_err   = restart_request & ~in_window;
  wire underflow    = presc_wrap & (count_ff == 12'h000);

  // reload has priority over counting so a restart never loses a tick race
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_ff <= `WWDT_COUNT_RESET;
      presc_ff <= 7'h0;
    end
    else if (cfg_write)
    begin
      count_ff <= w_data_ff[`WWDT_RELOAD_HI:`WWDT_RELOAD_LO];
      presc_ff <= 7'h0;
    end
    else if (good_restart)
    begin
      count_ff <= reload_value;
      presc_ff <= 7'h0;
    end
    else if (run_tick)
    begin
      presc_ff <= presc_ff + 7'h1;
      if (presc_wrap && count_ff != 12'h000)
        count_ff <= count_ff - 12'h001;
    end
  end

  // ****************************************************************
  // fault flags, interrupt and reset request
  // ****************************************************************
  // a new event in the same cycle as the clearing read wins
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unf_flag_ff      <= 1'b0;
      err_flag_ff      <= 1'b0;
      irq              <= 1'b0;
      fault_all_reset  <= 1'b0;
      fault_proc_reset <= 1'b0;
    end
    else
    begin
      unf_flag_ff <= underflow | (unf_flag_ff & ~sr_read);
      err_flag_ff <= window_err | (err_flag_ff & ~sr_read);
      irq <= fault_irq_enable &
             (((underflow | (unf_flag_ff & ~sr_read)) & irq_mask_ff[`WWDT_UNF_BIT]) |
              ((window_err | (err_flag_ff & ~sr_read)) & irq_mask_ff[`WWDT_ERR_BIT]));
      // fault line stays up until the flags are read or reset occurs
      fault_all_reset  <= fault_reset_enable & ~processor_only_reset &
                          (underflow | window_err | ((unf_flag_ff | err_flag_ff) & ~sr_read));
      fault_proc_reset <= fault_reset_enable & processor_only_reset &
                          (underflow | window_err | ((unf_flag_ff | err_flag_ff) & ~sr_read));
    end
  end

endmodule // wwdt_top

`default_nettype wire

// File: wwdt_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_map.vh"
// ****************************************************************
// bus handshake and fault line checks
// ****************************************************************
module wwdt_props
(
  // clock, reset and side inputs
  input wire logic        clk, resetn, slow_clk_tick, debug_state, idle_state,
  // bus payloads
  input wire logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  // bus handshakes
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  // fault outputs
  input wire logic        irq, fault_all_reset, fault_proc_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // flags read taken this cycle; fault lines may only fall after one
  wire fl_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `WWDT_OFS_FAULT);

  property p_b_fall; $fell(s_axi_bvalid) |-> $past(s_axi_bready); endproperty
  a_b_fall: assert property (p_b_fall) else $error("write response left early");
  property p_r_fall; $fell(s_axi_rvalid) |-> $past(s_axi_rready); endproperty
  a_r_fall: assert property (p_r_fall) else $error("read data left early");
  property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while response pending");
  property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken while data pending");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data not one cycle after take");
  property p_scope; !(fault_all_reset && fault_proc_reset); endproperty
  a_scope: assert property (p_scope) else $error("both reset scopes requested");
  property p_all_fall; $fell(fault_all_reset) |-> $past(fl_rd) || $past(fl_rd, 2) || $past(fl_rd, 3); endproperty
  a_all_fall: assert property (p_all_fall) else $error("full reset request dropped without read");
  property p_proc_fall; $fell(fault_proc_reset) |-> $past(fl_rd) || $past(fl_rd, 2) || $past(fl_rd, 3); endproperty
  a_proc_fall: assert property (p_proc_fall) else $error("processor reset request dropped without read");

  c_irq: cover property ($rose(irq));
  c_all: cover property ($rose(fault_all_reset));
  c_proc: cover property ($rose(fault_proc_reset));
endmodule // wwdt_props

bind wwdt_top wwdt_props wwdt_props_i (.*);
`default_nettype wire

// File: windowed_watchdog_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_map.vh"
module windowed_watchdog_timer_bench;
  reg        clk = 0, resetn = 0, debug_state = 0, idle_state = 0;
  reg [1:0]  slow_cnt = 0;
  reg [3:0]  awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, rv;
  reg        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [1:0]  rr;
  wire       awready, wready, bvalid, arready, rvalid, irq, f_all, f_proc;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer    mismatches = 0, compares = 0;

  always #10 clk = ~clk;
  // slow clock level holds two cycles, the shortest the synchroniser accepts
  always @(posedge clk) slow_cnt <= slow_cnt + 2'h1;

  wwdt_top wwdt_top_i (.clk(clk), .resetn(resetn), .slow_clk_tick(slow_cnt[1]), .debug_state(debug_state),
    .idle_state(idle_state), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .fault_all_reset(f_all),
    .fault_proc_reset(f_proc));

  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        mismatches++;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task hang;
    begin
      mismatches++;
      end_of_test;
    end
  endtask
  // both halves offered together; each dropped once taken
  task wr(input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 50 && !bvalid; n++)
      begin
        @(posedge clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end
      if (!bvalid) hang;
      rr = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    integer n;
    begin
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 50 && !rvalid; n++)
      begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
      end
      if (!rvalid) hang;
      rv = rdata; rr = rresp;
      rready <= 1'b0;
    end
  endtask
  task wait_irq(input integer lim);
    integer n;
    begin
      for (n = 0; n < lim && !irq; n++) @(posedge clk);
      if (!irq) hang;
    end
  endtask
  task do_reset;
    begin
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_defaults;
    begin
      rd(`WWDT_OFS_CONFIG); chk("config reset", rv, `WWDT_CFG_RESET);
      rd(`WWDT_OFS_FAULT); chk("flags reset", rv, 32'h0);
      rd(`WWDT_OFS_IRQ_MASK); chk("mask reset", rv, 32'h3);
      rd(4'h2); chk("unmapped resp", rr, `WWDT_AXI_SLVERR);
    end
  endtask
  // reload 3, window delta 2, both halts, irq and full reset enabled
  task t_window;
    begin
      wr(`WWDT_OFS_CONFIG, 32'h3002_3003);
      wr(`WWDT_OFS_CONFIG, 32'h0000_0000);
      rd(`WWDT_OFS_CONFIG); chk("config once", rv, 32'h3002_3003);
      wr(`WWDT_OFS_RESTART, 32'h5a00_0001);
      wr(`WWDT_OFS_RESTART, 32'ha500_0000);
      rd(`WWDT_OFS_FAULT); chk("ignored restarts", rv, 32'h0);
      wr(`WWDT_OFS_RESTART, 32'ha500_0001);
      repeat (3) @(posedge clk);
      chk("irq on error", irq, 1'b1);
      chk("all reset", f_all, 1'b1);
      chk("proc reset", f_proc, 1'b0);
      rd(`WWDT_OFS_FAULT); chk("error flag", rv, 32'h2);
      repeat (3) @(posedge clk);
      chk("irq cleared", irq, 1'b0);
      chk("reset cleared", f_all, 1'b0);
    end
  endtask
  // a non-halting counter would underflow inside either halt
  task t_halt_underflow;
    begin
      idle_state <= 1'b1;
      repeat (2500) @(posedge clk);
      idle_state <= 1'b0;
      rd(`WWDT_OFS_FAULT); chk("idle halt", rv, 32'h0);
      debug_state <= 1'b1;
      repeat (2500) @(posedge clk);
      debug_state <= 1'b0;
      rd(`WWDT_OFS_FAULT); chk("debug halt", rv, 32'h0);
      wait_irq(3000);
      chk("underflow reset", f_all, 1'b1);
      rd(`WWDT_OFS_FAULT); chk("underflow flag", rv, 32'h1);
      wr(`WWDT_OFS_RESTART, 32'ha500_0001);
      rd(`WWDT_OFS_FAULT); chk("restart in window", rv, 32'h0);
      repeat (1950) @(posedge clk);
      chk("no early underflow", irq, 1'b0);
      wait_irq(200);
      rd(`WWDT_OFS_FAULT); chk("timed underflow", rv, 32'h1);
    end
  endtask
  task t_scope;
    begin
      do_reset;
      wr(`WWDT_OFS_IRQ_MASK, 32'h1);
      wr(`WWDT_OFS_CONFIG, 32'h0000_7005);
      wr(`WWDT_OFS_RESTART, 32'ha500_0001);
      repeat (3) @(posedge clk);
      chk("masked irq", irq, 1'b0);
      chk("proc only", f_proc, 1'b1);
      chk("no full reset", f_all, 1'b0);
      rd(`WWDT_OFS_FAULT); chk("scope error flag", rv, 32'h2);
      rd(`WWDT_OFS_IRQ_MASK); chk("mask readback", rv, 32'h1);
    end
  endtask
  task t_disable;
    begin
      do_reset;
      wr(`WWDT_OFS_CONFIG, 32'h0000_b000);
      repeat (1500) @(posedge clk);
      rd(`WWDT_OFS_FAULT); chk("disabled", rv, 32'h0);
      chk("disabled reset", f_all, 1'b0);
    end
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_defaults;
    t_window;
    t_halt_underflow;
    t_scope;
    t_disable;
    end_of_test;
  end
endmodule // windowed_watchdog_timer_bench
`default_nettype wire
